// >>> hw/msg_engine_defs.vh
`ifndef MSG_ENGINE_DEFS_VH
`define MSG_ENGINE_DEFS_VH

// protocol limits
`define MSG_MAX_SEGS 16
`define MSG_MAX_PAYLOAD_BYTES 256
`define MSG_MAX_PAYLOAD_DW 32
`define MSG_DW_BYTES 8
`define MSG_DW_SHIFT 3
`define MSG_NUM_MBOX 4
`define MSG_NUM_LETTERS 4

// receive mailbox placement in local memory
`define MSG_MBOX_BASE 32'h0000_1000
`define MSG_MBOX_STRIDE 32'h0000_4000
`define MSG_LETTER_STRIDE 32'h0000_1000

// doorbell queue placement in local memory
`define MSG_DB_BASE 32'h0000_0100
`define MSG_DB_DEPTH 16

// transmit slot numbering: slots 0..3 are mailboxes, slot 4 the doorbell
`define MSG_DB_SLOT 3'h4

`endif

// >>> hw/message_mailbox_doorbell_engine.v
`timescale 1ns/1ns
`include "msg_engine_defs.vh"

module message_mailbox_doorbell_engine #(
    parameter AW = 32,
    parameter [4:0] TX_MAX_SEGS = 5'd16,
    parameter [5:0] TX_MAX_DW = 6'd32,
    parameter [4:0] RX_MAX_SEGS = 5'd16,
    parameter [5:0] RX_MAX_DW = 6'd32,
    parameter [2:0] RX_MBOXES = 3'd4,
    parameter [2:0] RX_LETTERS = 3'd4,
    parameter [2:0] TX_LETTERS = 3'd4
) (
    input wire clk_i,
    input wire sys_rst_i,
    // send configuration
    input wire tx_load_i,
    input wire tx_db_load_i,
    input wire [1:0] tx_mbox_i,
    input wire [1:0] tx_letter_i,
    input wire [7:0] tx_dest_i,
    input wire [AW-1:0] tx_addr_i,
    input wire [3:0] tx_msglen_i,
    input wire [5:0] tx_ssize_i,
    input wire [5:0] tx_last_size_i,
    input wire [15:0] tx_info_i,
    output reg [4:0] tx_busy_o,
    // local memory read port
    output reg mem_rd_req_o,
    output reg [AW-1:0] mem_rd_addr_o,
    input wire mem_rd_valid_i,
    input wire [63:0] mem_rd_data_i,
    // outgoing packet stream
    output reg pkt_out_valid_o,
    input wire pkt_out_ready_i,
    output reg pkt_out_sop_o,
    output reg pkt_out_eop_o,
    output reg [63:0] pkt_out_data_o,
    output reg pkt_out_doorbell_o,
    output reg [2:0] pkt_out_tid_o,
    output reg [7:0] pkt_out_dest_o,
    output reg [1:0] pkt_out_mbox_o,
    output reg [1:0] pkt_out_letter_o,
    output reg [3:0] pkt_out_msglen_o,
    output reg [3:0] pkt_out_msgseg_o,
    output reg [5:0] pkt_out_ssize_o,
    output reg [5:0] pkt_out_size_o,
    output reg [15:0] pkt_out_info_o,
    // responses to our requests
    input wire rsp_in_valid_i,
    input wire [2:0] rsp_in_tid_i,
    input wire rsp_in_retry_i,
    // incoming packet stream
    input wire pkt_in_valid_i,
    output reg pkt_in_ready_o,
    input wire pkt_in_sop_i,
    input wire pkt_in_eop_i,
    input wire [63:0] pkt_in_data_i,
    input wire pkt_in_doorbell_i,
    input wire [2:0] pkt_in_tid_i,
    input wire [7:0] pkt_in_src_i,
    input wire [1:0] pkt_in_mbox_i,
    input wire [1:0] pkt_in_letter_i,
    input wire [3:0] pkt_in_msglen_i,
    input wire [3:0] pkt_in_msgseg_i,
    input wire [5:0] pkt_in_ssize_i,
    input wire [15:0] pkt_in_info_i,
    // responses we return
    output reg rsp_out_valid_o,
    output reg [2:0] rsp_out_tid_o,
    output reg [7:0] rsp_out_dest_o,
    output reg rsp_out_retry_o,
    output reg rsp_out_error_o,
    // local memory write port, always accepts
    output reg mem_wr_o,
    output reg [AW-1:0] mem_wr_addr_o,
    output reg [63:0] mem_wr_data_o,
    // processor notification
    output reg [15:0] msg_done_o,
    input wire [15:0] msg_release_i,
    output reg db_pending_o,
    output reg [4:0] db_count_o,
    output reg [AW-1:0] db_head_addr_o,
    input wire db_pop_i
);

    localparam T_IDLE = 3'b001;
    localparam T_WAIT = 3'b010;
    localparam T_OUT = 3'b100;

    function [AW-1:0] seg_off;
        input [3:0] seg;
        input [5:0] ssize;
        reg [9:0] dws;
        begin
            // widen before multiplying: 15 x 32 doublewords needs nine bits
            dws = {6'h0, seg} * {4'h0, ssize};
            seg_off = {{(AW-10){1'b0}}, dws} << `MSG_DW_SHIFT;
        end
    endfunction

    function [AW-1:0] mbox_addr;
        input [1:0] mbox;
        input [1:0] letter;
        begin
            mbox_addr = `MSG_MBOX_BASE + mbox * `MSG_MBOX_STRIDE + letter * `MSG_LETTER_STRIDE;
        end
    endfunction

    // ---------------- send side ----------------
    reg [2:0] tstate;
    reg [4:0] s_wait;
    reg [3:0] s_seg [0:3];
    reg [3:0] s_len [0:3];
    reg [5:0] s_ssize [0:3];
    reg [5:0] s_last [0:3];
    reg [AW-1:0] s_addr [0:3];
    reg [1:0] s_letter [0:3];
    reg [7:0] s_dest [0:4];
    reg [15:0] s_info;
    reg [2:0] cur;
    reg [5:0] beat;
    reg [2:0] pick;
    reg pick_ok;
    integer i;
    integer p;

    wire [4:0] ready_slots = tx_busy_o & ~s_wait;
    wire tx_fits = ({1'b0, tx_msglen_i} < TX_MAX_SEGS) && (tx_ssize_i != 6'h0)
        && (tx_ssize_i <= TX_MAX_DW) && (tx_last_size_i != 6'h0)
        && (tx_last_size_i <= tx_ssize_i) && ({1'b0, tx_letter_i} < TX_LETTERS);

    // lowest mailbox wins; a packet in flight is never cut short
    always @* begin
        pick = 3'h0;
        pick_ok = 1'b0;
        for (p = 4; p >= 0; p = p - 1) begin
            if (ready_slots[p]) begin
                pick = p[2:0];
                pick_ok = 1'b1;
            end
        end
    end

    wire [1:0] pk = pick[1:0];
    wire [5:0] pick_size = (s_seg[pk] == s_len[pk]) ? s_last[pk] : s_ssize[pk];

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            tstate <= T_IDLE;
            tx_busy_o <= 5'h0;
            s_wait <= 5'h0;
            cur <= 3'h0;
            beat <= 6'h0;
            mem_rd_req_o <= 1'b0;
            mem_rd_addr_o <= {AW{1'b0}};
            pkt_out_valid_o <= 1'b0;
            pkt_out_sop_o <= 1'b0;
            pkt_out_eop_o <= 1'b0;
            pkt_out_data_o <= 64'h0;
            pkt_out_doorbell_o <= 1'b0;
            pkt_out_tid_o <= 3'h0;
            pkt_out_dest_o <= 8'h0;
            pkt_out_mbox_o <= 2'h0;
            pkt_out_letter_o <= 2'h0;
            pkt_out_msglen_o <= 4'h0;
            pkt_out_msgseg_o <= 4'h0;
            pkt_out_ssize_o <= 6'h0;
            pkt_out_size_o <= 6'h0;
            pkt_out_info_o <= 16'h0;
            s_info <= 16'h0;
            for (i = 0; i < 4; i = i + 1) begin
                s_seg[i] <= 4'h0;
                s_len[i] <= 4'h0;
                s_ssize[i] <= 6'h0;
                s_last[i] <= 6'h0;
                s_addr[i] <= {AW{1'b0}};
                s_letter[i] <= 2'h0;
                s_dest[i] <= 8'h0;
            end
            s_dest[4] <= 8'h0;
        end else begin
            mem_rd_req_o <= 1'b0;
            // software configures an idle mailbox slot; over-limit requests are ignored
            if (tx_load_i && !tx_busy_o[tx_mbox_i] && tx_fits) begin
                tx_busy_o[tx_mbox_i] <= 1'b1;
                s_seg[tx_mbox_i] <= 4'h0;
                s_len[tx_mbox_i] <= tx_msglen_i;
                s_ssize[tx_mbox_i] <= tx_ssize_i;
                s_last[tx_mbox_i] <= tx_last_size_i;
                s_addr[tx_mbox_i] <= tx_addr_i;
                s_letter[tx_mbox_i] <= tx_letter_i;
                s_dest[tx_mbox_i] <= tx_dest_i;
            end
            if (tx_db_load_i && !tx_busy_o[4]) begin
                tx_busy_o[4] <= 1'b1;
                s_info <= tx_info_i;
                s_dest[4] <= tx_dest_i;
            end
            // slot index is the id, so an id is only reissued after its answer
            if (rsp_in_valid_i && rsp_in_tid_i <= `MSG_DB_SLOT && s_wait[rsp_in_tid_i]) begin
                s_wait[rsp_in_tid_i] <= 1'b0;
                if (!rsp_in_retry_i) begin
                    if (rsp_in_tid_i == `MSG_DB_SLOT ||
                        s_seg[rsp_in_tid_i[1:0]] == s_len[rsp_in_tid_i[1:0]])
                        tx_busy_o[rsp_in_tid_i] <= 1'b0;
                    else
                        s_seg[rsp_in_tid_i[1:0]] <= s_seg[rsp_in_tid_i[1:0]] + 4'h1;
                end // a retried segment stays put and is sent again
            end
            case (tstate)
                T_IDLE: begin
                    if (pick_ok) begin
                        cur <= pick;
                        beat <= 6'h0;
                        pkt_out_tid_o <= pick;
                        pkt_out_dest_o <= s_dest[pick];
                        pkt_out_sop_o <= 1'b1;
                        if (pick == `MSG_DB_SLOT) begin
                            pkt_out_doorbell_o <= 1'b1;
                            pkt_out_info_o <= s_info;
                            pkt_out_size_o <= 6'h0;
                            pkt_out_data_o <= 64'h0;
                            pkt_out_eop_o <= 1'b1;
                            pkt_out_valid_o <= 1'b1;
                            tstate <= T_OUT;
                        end else begin
                            pkt_out_doorbell_o <= 1'b0;
                            pkt_out_mbox_o <= pk;
                            pkt_out_letter_o <= s_letter[pk];
                            pkt_out_msglen_o <= s_len[pk];
                            pkt_out_msgseg_o <= s_seg[pk];
                            pkt_out_ssize_o <= s_ssize[pk];
                            pkt_out_size_o <= pick_size;
                            mem_rd_req_o <= 1'b1;
                            mem_rd_addr_o <= s_addr[pk] + seg_off(s_seg[pk], s_ssize[pk]);
                            tstate <= T_WAIT;
                        end
                    end
                end
                T_WAIT: begin
                    if (mem_rd_valid_i) begin
                        pkt_out_data_o <= mem_rd_data_i;
                        pkt_out_eop_o <= (beat == pkt_out_size_o - 6'h1);
                        pkt_out_valid_o <= 1'b1;
                        tstate <= T_OUT;
                    end
                end
                T_OUT: begin
                    if (pkt_out_ready_i) begin
                        pkt_out_valid_o <= 1'b0;
                        pkt_out_sop_o <= 1'b0;
                        if (pkt_out_eop_o) begin
                            s_wait[cur] <= 1'b1;
                            tstate <= T_IDLE;
                        end else begin
                            beat <= beat + 6'h1;
                            mem_rd_req_o <= 1'b1;
                            mem_rd_addr_o <= mem_rd_addr_o + `MSG_DW_BYTES;
                            tstate <= T_WAIT;
                        end
                    end
                end
                default: tstate <= T_IDLE;
            endcase
        end
    end

    // ---------------- receive side ----------------
    reg [15:0] seg_mask [0:15];
    reg [3:0] rx_len [0:15];
    reg [3:0] db_wp;
    reg [3:0] db_rp;
    reg r_write, r_retry, r_error, r_db;
    reg [3:0] r_idx;
    reg [3:0] r_seg;
    reg [2:0] r_tid;
    reg [7:0] r_src;
    reg [AW-1:0] r_addr;
    integer ri;

    wire in_beat = pkt_in_valid_i & pkt_in_ready_o;
    wire [3:0] in_idx = {pkt_in_mbox_i, pkt_in_letter_i};
    wire db_full = (db_count_o == `MSG_DB_DEPTH);
    wire in_unsup = ({1'b0, pkt_in_mbox_i} >= RX_MBOXES) || ({1'b0, pkt_in_letter_i} >= RX_LETTERS)
        || ({1'b0, pkt_in_msglen_i} >= RX_MAX_SEGS) || (pkt_in_ssize_i == 6'h0)
        || (pkt_in_ssize_i > RX_MAX_DW) || (pkt_in_msgseg_i > pkt_in_msglen_i);
    wire in_busy = msg_done_o[in_idx] ||
        (seg_mask[in_idx] != 16'h0 && rx_len[in_idx] != pkt_in_msglen_i);
    wire k_db = pkt_in_sop_i ? pkt_in_doorbell_i : r_db;
    wire k_write = pkt_in_sop_i ? (!pkt_in_doorbell_i && !in_unsup && !in_busy) : r_write;
    wire k_retry = pkt_in_sop_i ? (pkt_in_doorbell_i ? db_full : (!in_unsup && in_busy)) : r_retry;
    wire k_error = pkt_in_sop_i ? (!pkt_in_doorbell_i && in_unsup) : r_error;
    wire [3:0] k_idx = pkt_in_sop_i ? in_idx : r_idx;
    wire [3:0] k_seg = pkt_in_sop_i ? pkt_in_msgseg_i : r_seg;
    // address depends only on header fields, never on earlier arrivals
    wire [AW-1:0] k_addr = pkt_in_sop_i ?
        mbox_addr(pkt_in_mbox_i, pkt_in_letter_i) + seg_off(pkt_in_msgseg_i, pkt_in_ssize_i)
        : r_addr;
    wire [15:0] k_mask = seg_mask[k_idx] | (16'h1 << k_seg);
    // a first-arriving single-beat segment must not see the previous letter's length
    wire [3:0] k_len = pkt_in_sop_i ? pkt_in_msglen_i : rx_len[k_idx];
    wire [15:0] k_full = (16'h2 << k_len) - 16'h1;
    wire db_pop = db_pop_i && db_count_o != 5'h0;
    wire db_push = in_beat && pkt_in_sop_i && pkt_in_doorbell_i && !db_full;

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            pkt_in_ready_o <= 1'b0;
            rsp_out_valid_o <= 1'b0;
            rsp_out_tid_o <= 3'h0;
            rsp_out_dest_o <= 8'h0;
            rsp_out_retry_o <= 1'b0;
            rsp_out_error_o <= 1'b0;
            mem_wr_o <= 1'b0;
            mem_wr_addr_o <= {AW{1'b0}};
            mem_wr_data_o <= 64'h0;
            msg_done_o <= 16'h0;
            db_pending_o <= 1'b0;
            db_count_o <= 5'h0;
            db_head_addr_o <= `MSG_DB_BASE;
            db_wp <= 4'h0;
            db_rp <= 4'h0;
            r_write <= 1'b0;
            r_retry <= 1'b0;
            r_error <= 1'b0;
            r_db <= 1'b0;
            r_idx <= 4'h0;
            r_seg <= 4'h0;
            r_tid <= 3'h0;
            r_src <= 8'h0;
            r_addr <= {AW{1'b0}};
            for (ri = 0; ri < 16; ri = ri + 1) begin
                seg_mask[ri] <= 16'h0;
                rx_len[ri] <= 4'h0;
            end
        end else begin
            // input never waits on the output side; every packet is consumed
            pkt_in_ready_o <= 1'b1;
            mem_wr_o <= 1'b0;
            rsp_out_valid_o <= 1'b0;
            for (ri = 0; ri < 16; ri = ri + 1) begin
                if (msg_release_i[ri] && msg_done_o[ri]) begin
                    msg_done_o[ri] <= 1'b0;
                    seg_mask[ri] <= 16'h0;
                end
            end
            if (in_beat) begin
                if (pkt_in_sop_i) begin
                    r_db <= k_db;
                    r_write <= k_write;
                    r_retry <= k_retry;
                    r_error <= k_error;
                    r_idx <= k_idx;
                    r_seg <= k_seg;
                    r_tid <= pkt_in_tid_i;
                    r_src <= pkt_in_src_i;
                    if (k_write)
                        rx_len[in_idx] <= pkt_in_msglen_i;
                end
                if (k_write) begin
                    mem_wr_o <= 1'b1;
                    mem_wr_addr_o <= k_addr;
                    mem_wr_data_o <= pkt_in_data_i;
                    r_addr <= k_addr + `MSG_DW_BYTES;
                end
                if (db_push) begin
                    mem_wr_o <= 1'b1;
                    mem_wr_addr_o <= `MSG_DB_BASE + {{(AW-7){1'b0}}, db_wp, 3'b000};
                    mem_wr_data_o <= {40'h0, pkt_in_src_i, pkt_in_info_i};
                    db_wp <= db_wp + 4'h1;
                end
                if (pkt_in_eop_i) begin
                    rsp_out_valid_o <= 1'b1;
                    rsp_out_tid_o <= pkt_in_sop_i ? pkt_in_tid_i : r_tid;
                    rsp_out_dest_o <= pkt_in_sop_i ? pkt_in_src_i : r_src;
                    rsp_out_retry_o <= k_retry;
                    rsp_out_error_o <= k_error;
                    if (k_write) begin
                        seg_mask[k_idx] <= k_mask;
                        if (k_mask == k_full)
                            msg_done_o[k_idx] <= 1'b1;
                    end
                end
            end
            if (db_pop) begin
                db_rp <= db_rp + 4'h1;
                db_head_addr_o <= `MSG_DB_BASE + {{(AW-7){1'b0}}, db_rp + 4'h1, 3'b000};
            end
            db_count_o <= db_count_o + {4'h0, db_push} - {4'h0, db_pop};
            db_pending_o <= (db_count_o + {4'h0, db_push} - {4'h0, db_pop}) != 5'h0;
        end
    end

endmodule

// >>> tb/msg_engine_assertions.sv
`timescale 1ns/1ns
module msg_engine_checker (
    input wire clk_i,
    input wire sys_rst_i,
    input wire tx_load_i,
    input wire [4:0] tx_busy_o,
    input wire pkt_out_valid_o,
    input wire pkt_out_ready_i,
    input wire pkt_out_sop_o,
    input wire pkt_out_eop_o,
    input wire [63:0] pkt_out_data_o,
    input wire pkt_out_doorbell_o,
    input wire [5:0] pkt_out_ssize_o,
    input wire [5:0] pkt_out_size_o,
    input wire pkt_in_valid_i,
    input wire pkt_in_ready_o,
    input wire pkt_in_eop_i,
    input wire rsp_out_valid_o,
    input wire rsp_out_retry_o,
    input wire mem_wr_o,
    input wire [15:0] msg_done_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence beat_in_s;
        pkt_in_valid_i && pkt_in_ready_o;
    endsequence
    sequence eop_in_s;
        beat_in_s ##0 pkt_in_eop_i;
    endsequence
    sequence stall_s;
        pkt_out_valid_o && !pkt_out_ready_i;
    endsequence
    busy_needs_load_a: assert property (
        |(tx_busy_o[3:0] & ~$past(tx_busy_o[3:0])) |-> $past(tx_load_i))
        else $error("mailbox slot busy without a load");
    out_hold_a: assert property (stall_s |=> pkt_out_valid_o && $stable(pkt_out_data_o))
        else $error("stalled packet beat dropped or changed");
    in_ready_a: assert property (!$past(sys_rst_i) |-> pkt_in_ready_o)
        else $error("input port stopped accepting");
    db_no_payload_a: assert property (
        pkt_out_valid_o && pkt_out_doorbell_o |-> pkt_out_sop_o && pkt_out_eop_o
        && pkt_out_size_o == 6'h0) else $error("doorbell carries a payload");
    pkt_size_a: assert property (
        pkt_out_valid_o && !pkt_out_doorbell_o |-> pkt_out_size_o inside {[1:32]}
        && pkt_out_size_o <= pkt_out_ssize_o) else $error("packet payload size out of range");
    wr_from_beat_a: assert property (mem_wr_o |-> $past(pkt_in_valid_i) && $past(pkt_in_ready_o))
        else $error("memory write without an accepted beat");
    rsp_after_eop_a: assert property (eop_in_s |=> rsp_out_valid_o)
        else $error("no response after last beat");
    done_with_rsp_a: assert property (
        |(msg_done_o & ~$past(msg_done_o)) |-> rsp_out_valid_o && !rsp_out_retry_o)
        else $error("message done without a final accepted segment");
endmodule
bind message_mailbox_doorbell_engine msg_engine_checker i_msg_engine_checker (.*);

// >>> tb/remote_element_model.sv
`timescale 1ns/1ns
module remote_element_model (
    input wire clk_i,
    input wire sys_rst_i,
    input wire retry_once,
    input wire pkt_out_valid_o,
    input wire pkt_out_eop_o,
    input wire [2:0] pkt_out_tid_o,
    output reg pkt_out_ready_i = 0,
    output reg rsp_in_valid_i = 0,
    output reg [2:0] rsp_in_tid_i = 0,
    output reg rsp_in_retry_i = 0
);
    reg [2:0] pend[$];
    reg arm = 0;
    integer j;
    always @(posedge clk_i) begin
        pkt_out_ready_i <= !sys_rst_i && $urandom % 4 != 0;
        rsp_in_valid_i <= 0;
        // idle lines toggle so a stale tid is never mistaken for an answer
        rsp_in_tid_i <= ~rsp_in_tid_i;
        rsp_in_retry_i <= ~rsp_in_retry_i;
        if (pkt_out_valid_o && pkt_out_ready_i && pkt_out_eop_o) begin
            pend.push_back(pkt_out_tid_o);
        end else if (pend.size() != 0 && $urandom % 3 == 0) begin
            j = $urandom % pend.size();
            rsp_in_valid_i <= 1;
            rsp_in_tid_i <= pend[j];
            rsp_in_retry_i <= arm;
            arm <= 0;
            pend.delete(j);
        end
        if (retry_once) arm <= 1;
    end
endmodule

// >>> tb/message_mailbox_doorbell_engine_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module message_mailbox_doorbell_engine_tb;
    reg clk_i = 0, sys_rst_i = 1, tx_load_i = 0, tx_db_load_i = 0, mem_rd_valid_i = 0;
    reg pkt_in_valid_i = 0, pkt_in_sop_i = 0, pkt_in_eop_i = 0, pkt_in_doorbell_i = 0;
    reg db_pop_i = 0, retry_once = 0;
    reg [1:0] tx_mbox_i = 0, tx_letter_i = 0, pkt_in_mbox_i = 0, pkt_in_letter_i = 0;
    reg [2:0] pkt_in_tid_i = 0;
    reg [3:0] tx_msglen_i = 0, pkt_in_msglen_i = 0, pkt_in_msgseg_i = 0;
    reg [5:0] tx_ssize_i = 0, tx_last_size_i = 0, pkt_in_ssize_i = 0;
    reg [7:0] tx_dest_i = 0, pkt_in_src_i = 0;
    reg [15:0] tx_info_i = 0, pkt_in_info_i = 0, msg_release_i = 0, dm = 0;
    reg [31:0] tx_addr_i = 0, a;
    reg [63:0] mem_rd_data_i = 0, pkt_in_data_i = 0;
    wire pkt_out_ready_i, rsp_in_valid_i, rsp_in_retry_i, mem_rd_req_o, pkt_out_valid_o;
    wire pkt_out_sop_o, pkt_out_eop_o, pkt_out_doorbell_o, pkt_in_ready_o, rsp_out_valid_o;
    wire rsp_out_retry_o, rsp_out_error_o, mem_wr_o, db_pending_o;
    wire [1:0] pkt_out_mbox_o, pkt_out_letter_o;
    wire [2:0] rsp_in_tid_i, pkt_out_tid_o, rsp_out_tid_o;
    wire [3:0] pkt_out_msglen_o, pkt_out_msgseg_o;
    wire [4:0] tx_busy_o, db_count_o;
    wire [5:0] pkt_out_ssize_o, pkt_out_size_o;
    wire [7:0] pkt_out_dest_o, rsp_out_dest_o;
    wire [15:0] pkt_out_info_o, msg_done_o;
    wire [31:0] mem_rd_addr_o, mem_wr_addr_o, db_head_addr_o;
    wire [63:0] pkt_out_data_o, mem_wr_data_o;
    integer failures = 0, n_tests = 0, i, k, s, z, wp = 0, rp = 0, dbn = 0;
    integer tlen[0:4], tss[0:4], tlast[0:4], nseg[0:4], bc[0:4], mlen[0:15];
    reg [31:0] tbase[0:4];
    reg [1:0] tlet[0:4];
    reg [7:0] tdest[0:4];
    reg [15:0] seen[0:15];
    reg [4:0] outst = 0;
    reg [95:0] wq[$];
    reg [12:0] rq[$];

    // mailbox 3 left unsupported on receive so the error answer is reachable
    message_mailbox_doorbell_engine #(.RX_MBOXES(3'd3)) i_message_mailbox_doorbell_engine (.*);
    remote_element_model i_remote_element_model (.*);

    always #50 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        mem_rd_valid_i <= mem_rd_req_o;
        mem_rd_data_i <= mem_rd_req_o ? {~mem_rd_addr_o, mem_rd_addr_o} : {2{$urandom}};
    end

    always @(posedge clk_i) begin
        if (mem_wr_o) begin
            `CHK("wr", wq.size() ? wq[0] : 96'h0, {mem_wr_addr_o, mem_wr_data_o})
            if (wq.size()) void'(wq.pop_front());
        end
        if (rsp_out_valid_o) begin
            `CHK("rsp", rq.size() ? rq[0] : 13'h0, {rsp_out_tid_o, rsp_out_dest_o, rsp_out_retry_o, rsp_out_error_o})
            if (rq.size()) void'(rq.pop_front());
        end
        if (pkt_out_valid_o && pkt_out_ready_i) begin
            s = pkt_out_doorbell_o ? 4 : pkt_out_mbox_o;
            if (pkt_out_sop_o) bc[s] = 0;
            if (pkt_out_sop_o) `CHK("tid free", 1'b0, outst[s])
            `CHK("tid", s[2:0], pkt_out_tid_o)
            `CHK("dest", tdest[s], pkt_out_dest_o)
            if (s == 4) begin
                `CHK("info", 16'h5a04, pkt_out_info_o)
            end else begin
                a = tbase[s] + (nseg[s] * tss[s] + bc[s]) * 8;
                z = nseg[s] == tlen[s] ? tlast[s] : tss[s];
                `CHK("seg", nseg[s], pkt_out_msgseg_o)
                `CHK("let", tlet[s], pkt_out_letter_o)
                `CHK("len", tlen[s][3:0], pkt_out_msglen_o)
                `CHK("ssize", tss[s][5:0], pkt_out_ssize_o)
                `CHK("data", {~a, a}, pkt_out_data_o)
                `CHK("size", z, pkt_out_size_o)
                `CHK("eop", bc[s] + 1 == z, pkt_out_eop_o)
            end
            bc[s]++;
            if (pkt_out_eop_o) outst[s] = 1;
        end
        if (rsp_in_valid_i) begin
            outst[rsp_in_tid_i] = 0;
            if (!rsp_in_retry_i) nseg[rsp_in_tid_i]++;
        end
    end

    task rx(input db, input [1:0] m, input [1:0] l, input [3:0] len, input [3:0] sg,
            input [5:0] ss, input integer nb);
        integer b, ix;
        reg rt, er;
        reg [63:0] d;
        begin
            ix = m * 4 + l;
            er = !db && m > 2;
            rt = db ? dbn == 16 : !er && (dm[ix] || (seen[ix] != 0 && len != mlen[ix]));
            {pkt_in_doorbell_i, pkt_in_mbox_i, pkt_in_letter_i} <= {db, m, l};
            {pkt_in_msglen_i, pkt_in_msgseg_i, pkt_in_ssize_i} <= {len, sg, ss};
            pkt_in_src_i <= 8'h10 + ix;
            pkt_in_tid_i <= ix;
            for (b = 0; b < nb; b++) begin
                d = {$urandom, $urandom};
                {pkt_in_valid_i, pkt_in_sop_i, pkt_in_eop_i} <= {1'b1, b == 0, b == nb - 1};
                pkt_in_data_i <= d;
                pkt_in_info_i <= d[15:0];
                if (!(rt || er || db))
                    wq.push_back({32'h1000 + m * 32'h4000 + l * 32'h1000 + (sg * ss + b) * 8, d});
                @(posedge clk_i);
                `CHK("ready", 1'b1, pkt_in_ready_o)
            end
            pkt_in_valid_i <= 0;
            pkt_in_data_i <= ~d;
            if (db && !rt) begin
                wq.push_back({32'h100 + wp * 8, 40'h0, 8'h10 + ix[7:0], d[15:0]});
                wp = (wp + 1) % 16;
                dbn++;
            end
            if (!(rt || er || db)) begin
                mlen[ix] = len;
                seen[ix][sg] = 1;
                dm[ix] = $countones(seen[ix]) == len + 1;
            end
            rq.push_back({ix[2:0], 8'h10 + ix[7:0], rt, er});
            repeat (2) @(posedge clk_i);
            `CHK("done", dm, msg_done_o)
            `CHK("db count", dbn, db_count_o)
            `CHK("db head", 32'h100 + rp * 8, db_head_addr_o)
            `CHK("db pend", dbn != 0, db_pending_o)
        end
    endtask

    task load(input integer m, input [3:0] len, input [5:0] ss, input [5:0] ls);
        begin
            tlet[m] = $urandom % 4;
            tdest[m] = $urandom % 256;
            {tx_load_i, tx_db_load_i, tx_mbox_i} <= {m < 4, m == 4, m[1:0]};
            {tx_msglen_i, tx_ssize_i, tx_last_size_i} <= {len, ss, ls};
            tx_letter_i <= tlet[m];
            tx_dest_i <= tdest[m];
            tx_addr_i <= 32'h8000 * (m + 1);
            tx_info_i <= 16'h5a00 + m;
            tbase[m] = 32'h8000 * (m + 1);
            tlen[m] = len;
            tss[m] = ss;
            tlast[m] = ls;
            nseg[m] = 0;
            @(posedge clk_i);
            {tx_load_i, tx_db_load_i} <= 2'b00;
            @(posedge clk_i);
        end
    endtask

    task finish_test;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask

    initial begin
        void'($urandom(32'hae3e));
        for (i = 0; i < 16; i++) seen[i] = 0;
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 0;
        @(posedge clk_i);
        `CHK("rst head", 32'h100, db_head_addr_o)
        @(posedge clk_i);
        // two letters of one mailbox interleaved, segments reversed and shuffled
        for (i = 0; i < 4; i++) begin
            rx(0, 2, 1, 3, (i * 3 + 1) % 4, 4, (i * 3 + 1) % 4 == 3 ? 2 : 4);
            if (i < 2) rx(0, 2, 2, 1, 1 - i, 1, 1);
        end
        rx(0, 2, 1, 3, 0, 4, 4);
        rx(0, 2, 3, 1, 0, 2, 2);
        rx(0, 2, 3, 2, 1, 2, 2);
        rx(0, 3, 0, 0, 0, 1, 1);
        rx(0, 0, 0, 0, 0, 32, 32);
        msg_release_i <= 16'h0200;
        @(posedge clk_i);
        msg_release_i <= 0;
        dm[9] = 0;
        seen[9] = 0;
        rx(0, 2, 1, 0, 0, 1, 1);
        for (i = 0; i < 17; i++) rx(1, $urandom, $urandom, 0, 0, 0, 1);
        repeat (2) begin
            db_pop_i <= 1;
            @(posedge clk_i);
            db_pop_i <= 0;
            rp = (rp + 1) % 16;
            dbn--;
            @(posedge clk_i);
        end
        rx(1, 1, 1, 0, 0, 0, 1);
        load(3, 15, 2, 1);
        load(4, 0, 0, 0);
        retry_once <= 1;
        @(posedge clk_i);
        retry_once <= 0;
        load(1, 0, 0, 0);
        load(0, 2, 32, 32);
        `CHK("refused", 1'b0, tx_busy_o[1])
        for (k = 0; k < 3000 && tx_busy_o[0] !== 1'b0; k++) @(posedge clk_i);
        `CHK("tx0 done", 1'b0, tx_busy_o[0])
        `CHK("prio", 1'b1, tx_busy_o[3])
        for (k = 0; k < 5000 && tx_busy_o !== 5'h0; k++) @(posedge clk_i);
        `CHK("tx idle", 5'h0, tx_busy_o)
        `CHK("segs", 16, nseg[3])
        `CHK("segs", 3, nseg[0])
        `CHK("segs", 1, nseg[4])
        repeat (4) @(posedge clk_i);
        `CHK("drained", 0, wq.size() + rq.size())
        finish_test;
    end
endmodule
